// File: logic/dcr_top.sv
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps
// Contract
// - Enable-clear bit aborts only that channel
// - Channel 21 does flash keyhole writes
// - Flash channel done raises enabled interrupt
// - Select register picks trigger zero source
// - Four options map to four PLA sources
// - Exponent sets transfers per request
// - Alternate base read-only, resets 0x200
// - Primary base read-write, resets zero
// - Writing one raises software request
// - Enable, mask, alternate: set and clear
// - Priority set/clear both write-only
// - Swap and decrements: set and clear
// - Error flags readable, cleared separately
// - Routing registers all reset to zero
// - Status bits 20:16 show channels less one
// - Software request clears when transfer completes
// - Trigger channels are 27 and 28
module dcr_top
    import dcr_pkg::*;
#(
    parameter logic [31:0] REVISION = 32'h0000_0010 // Arbitrary value
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [31:0]      wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    input  wire logic [NCH-1:0]   periph_req,
    input  wire logic [NCH-1:0]   chan_done,
    input  wire logic [NCH-1:0]   chan_err_evt,
    input  wire logic [NCH-1:0]   inv_desc_evt,
    input  wire logic             bus_err_evt,
    input  wire logic [NPLA-1:0]  pla_req,
    input  wire logic [NTMR-1:0]  timer_req,
    output logic      [NCH-1:0]   dma_req,
    output logic      [NCH-1:0]   chan_enable,
    output logic      [NCH-1:0]   chan_abort,
    output logic      [NCH-1:0]   chan_mask,
    output logic      [NCH-1:0]   chan_alt,
    output logic      [NCH-1:0]   chan_pri,
    output logic      [NCH-1:0]   byte_swap,
    output logic      [NCH-1:0]   src_dec,
    output logic      [NCH-1:0]   dst_dec,
    output logic                  ctrl_enable,
    output logic      [31:0]      primary_base,
    output logic      [31:0]      alternate_base,
    output logic      [10:0]      burst_len_zero,
    output logic      [10:0]      burst_len_one,
    output logic                  flash_block_sel,
    output logic                  flash_dma_irq
);

    typedef struct packed {
        logic            ack;
        logic [31:0]     rdata;
        logic            men;
        logic [31:0]     pdb;
        logic [NCH-1:0]  sw_req;
        logic [NCH-1:0]  mask;
        logic [NCH-1:0]  en;
        logic [NCH-1:0]  alt;
        logic [NCH-1:0]  pri;
        logic [NCH-1:0]  cherr;
        logic            buserr;
        logic [NCH-1:0]  invd;
        logic [NCH-1:0]  bs;
        logic [NCH-1:0]  sdec;
        logic [NCH-1:0]  ddec;
        logic [7:0]      trig_en;
        logic [7:0]      sel0;
        logic [7:0]      sel1;
        logic [7:0]      pla_en;
        logic [7:0]      tmr_en;
        logic [15:0]     ttype;
        logic [7:0]      burst;
        logic [1:0]      flash;
        logic            irq;
        logic [NCH-1:0]  abort;
        logic [NCH-1:0]  req;
        logic [NTMR-1:0] tmr_prev;
    } dcr_state_type;

    dcr_state_type   st_q;
    dcr_state_type   st_d;
    logic            acc;
    logic            wr;
    logic [31:0]     wmask;
    logic [31:0]     wd;
    logic [NCH-1:0]  wch;
    logic [NTMR-1:0] tmr_evt;
    logic [NTRIG-1:0] trig_hit;
    logic [7:0]      trig_sel [NTRIG];

    ////////////////////////////////////////////////////////////////////////
    // Bus strobes

    // One access per handshake; ack drops the cycle after it rose
    assign acc   = wb_cyc_i && wb_stb_i && !st_q.ack;
    assign wr    = acc && wb_we_i;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                    {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wd    = wb_dat_i & wmask;
    assign wch   = wd[NCH-1:0];

    ////////////////////////////////////////////////////////////////////////
    // Request routing

    assign trig_sel[0] = st_q.sel0;
    assign trig_sel[1] = st_q.sel1;

    genvar gi;
    generate
        for (gi = 0; gi < NTMR; gi++) begin : g_tmr
            // Odd type bits are spare; even bit picks edge over level
            assign tmr_evt[gi] = st_q.ttype[2*gi] ?
                timer_req[gi] && !st_q.tmr_prev[gi] : timer_req[gi];
        end
        for (gi = 0; gi < NTRIG; gi++) begin : g_trig
            // Options 0..3 are the four PLA sources' requests
            assign trig_hit[gi] = st_q.trig_en[gi] && (
                (trig_sel[gi] < SEL_TMR_BASE) ?
                st_q.pla_en[trig_sel[gi][1:0]] && pla_req[trig_sel[gi][1:0]] :
                (trig_sel[gi] < SEL_TMR_BASE + 8'h04) &&
                st_q.tmr_en[trig_sel[gi][1:0]] &&
                tmr_evt[trig_sel[gi][1:0]]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic [NCH-1:0] src;
        src  = periph_req;
        st_d = st_q;
        src[TRIG_CH0] = trig_hit[0];
        src[TRIG_CH1] = trig_hit[1];
        st_d.ack      = acc;
        st_d.abort    = '0;
        st_d.tmr_prev = timer_req;
        // Completion drops software requests; a new write below wins
        st_d.sw_req   = st_q.sw_req & ~chan_done;
        st_d.cherr    = st_q.cherr | chan_err_evt;
        st_d.invd     = st_q.invd | inv_desc_evt;
        st_d.buserr   = st_q.buserr | bus_err_evt;
        st_d.irq      = chan_done[FLASH_CH] && st_q.flash[FLASH_IRQ_EN];
        if (acc) begin
            st_d.rdata = 32'h0000_0000;
            case (wb_adr_i)
                A_TRIG_EN:    st_d.rdata = {24'h0, st_q.trig_en};
                A_TRIG_SEL0:  st_d.rdata = {24'h0, st_q.sel0};
                A_TRIG_SEL1:  st_d.rdata = {24'h0, st_q.sel1};
                A_PLA_EN:     st_d.rdata = {24'h0, st_q.pla_en};
                A_TMR_EN:     st_d.rdata = {24'h0, st_q.tmr_en};
                A_TMR_TYPE:   st_d.rdata = {16'h0, st_q.ttype};
                A_TRIG_BURST: st_d.rdata = {24'h0, st_q.burst};
                A_STAT:       st_d.rdata = STAT_RST |
                                           {31'h0, st_q.men};
                A_PDB:        st_d.rdata = st_q.pdb;
                A_ADB:        st_d.rdata = ADB_RST;
                A_MSK_SET:    st_d.rdata = {1'b0, st_q.mask};
                A_EN_SET:     st_d.rdata = {1'b0, st_q.en};
                A_ALT_SET:    st_d.rdata = {1'b0, st_q.alt};
                A_CHERR_CLR:  st_d.rdata = {1'b0, st_q.cherr};
                A_BUSERR_CLR: st_d.rdata = {31'h0, st_q.buserr};
                A_INVD_CLR:   st_d.rdata = {1'b0, st_q.invd};
                A_FLASH_CTRL: st_d.rdata = {30'h0, st_q.flash};
                A_BS_SET:     st_d.rdata = {1'b0, st_q.bs};
                A_SDEC_SET:   st_d.rdata = {1'b0, st_q.sdec};
                A_DDEC_SET:   st_d.rdata = {1'b0, st_q.ddec};
                A_REV_ID:     st_d.rdata = REVISION;
                default:      st_d.rdata = 32'h0000_0000;
            endcase
        end
        if (wr) begin
            st_d.rdata = 32'h0000_0000;
            // Set/clear writes touch only the one bits, sel-gated
            case (wb_adr_i)
                A_TRIG_EN:    st_d.trig_en = (st_q.trig_en & ~wmask[7:0]) |
                                             wd[7:0];
                A_TRIG_SEL0:  st_d.sel0   = (st_q.sel0 & ~wmask[7:0]) | wd[7:0];
                A_TRIG_SEL1:  st_d.sel1   = (st_q.sel1 & ~wmask[7:0]) | wd[7:0];
                A_PLA_EN:     st_d.pla_en = (st_q.pla_en & ~wmask[7:0]) |
                                            wd[7:0];
                A_TMR_EN:     st_d.tmr_en = (st_q.tmr_en & ~wmask[7:0]) |
                                            wd[7:0];
                A_TMR_TYPE:   st_d.ttype  = (st_q.ttype & ~wmask[15:0]) |
                                            wd[15:0];
                A_TRIG_BURST: st_d.burst  = (st_q.burst & ~wmask[7:0]) |
                                            wd[7:0];
                // Clearing the enable here can wreck descriptors in flight
                A_CFG:        if (wb_sel_i[0]) st_d.men = wd[0];
                A_PDB:        st_d.pdb  = (st_q.pdb & ~wmask) | wd;
                A_SW_REQ:     st_d.sw_req = st_d.sw_req | wch;
                A_MSK_SET:    st_d.mask = st_q.mask | wch;
                A_MSK_CLR:    st_d.mask = st_q.mask & ~wch;
                A_EN_SET:     st_d.en   = st_q.en | wch;
                A_EN_CLR: begin
                    st_d.en    = st_q.en & ~wch;
                    st_d.abort = st_q.en & wch;
                end
                A_ALT_SET:    st_d.alt  = st_q.alt | wch;
                A_ALT_CLR:    st_d.alt  = st_q.alt & ~wch;
                A_PRI_SET:    st_d.pri  = st_q.pri | wch;
                A_PRI_CLR:    st_d.pri  = st_q.pri & ~wch;
                // Events in the clearing cycle survive
                A_CHERR_CLR:  st_d.cherr = (st_q.cherr & ~wch) | chan_err_evt;
                A_BUSERR_CLR: st_d.buserr = (st_q.buserr & ~wd[0]) |
                                            bus_err_evt;
                A_INVD_CLR:   st_d.invd = (st_q.invd & ~wch) | inv_desc_evt;
                A_FLASH_CTRL: st_d.flash = (st_q.flash & ~wmask[1:0]) |
                                           wd[1:0];
                A_BS_SET:     st_d.bs   = st_q.bs | wch;
                A_BS_CLR:     st_d.bs   = st_q.bs & ~wch;
                A_SDEC_SET:   st_d.sdec = st_q.sdec | wch;
                A_SDEC_CLR:   st_d.sdec = st_q.sdec & ~wch;
                A_DDEC_SET:   st_d.ddec = st_q.ddec | wch;
                A_DDEC_CLR:   st_d.ddec = st_q.ddec & ~wch;
                default:      st_d.men  = st_q.men;
            endcase
        end
        // Mask blocks hardware requests only; software ones still pass
        st_d.req = ((src & ~st_q.mask) | st_q.sw_req) & st_q.en &
                   {NCH{st_q.men}};
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_q      <= '0;
            st_q.pdb  <= PDB_RST;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign wb_ack_o        = st_q.ack;
    assign wb_dat_o        = st_q.rdata;
    assign dma_req         = st_q.req;
    assign chan_enable     = st_q.en;
    assign chan_abort      = st_q.abort;
    assign chan_mask       = st_q.mask;
    assign chan_alt        = st_q.alt;
    assign chan_pri        = st_q.pri;
    assign byte_swap       = st_q.bs;
    assign src_dec         = st_q.sdec;
    assign dst_dec         = st_q.ddec;
    assign ctrl_enable     = st_q.men;
    assign primary_base    = st_q.pdb;
    assign alternate_base  = ADB_RST;
    // Exponent n gives 2**n transfers per request; values above 10 saturate
    assign burst_len_zero  = (st_q.burst[3:0] > 4'ha) ? 11'h400 :
                             11'h001 << st_q.burst[3:0];
    assign burst_len_one   = (st_q.burst[7:4] > 4'ha) ? 11'h400 :
                             11'h001 << st_q.burst[7:4];
    assign flash_block_sel = st_q.flash[FLASH_BLOCK];
    assign flash_dma_irq   = st_q.irq;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_abort;
        wr && wb_adr_i == A_EN_CLR && wb_sel_i[0] && wb_dat_i[4]
        |=> !chan_enable[4] && chan_abort[4] == $past(st_q.en[4]);
    endproperty
    a_abort: assert property (p_abort)
        else $error("enable clear did not stop channel");

    property p_keep;
        wr && wb_adr_i == A_EN_CLR && !wb_dat_i[5]
        |=> chan_enable[5] == $past(chan_enable[5]);
    endproperty
    a_keep: assert property (p_keep)
        else $error("clear changed an unaddressed channel");

    property p_flash_irq;
        flash_dma_irq |-> $past(chan_done[FLASH_CH]) &&
                          $past(st_q.flash[FLASH_IRQ_EN]);
    endproperty
    a_flash_irq: assert property (p_flash_irq)
        else $error("flash interrupt without enabled completion");

    property p_stat;
        acc && !wb_we_i && wb_adr_i == A_STAT
        |=> wb_ack_o && wb_dat_o[STAT_CH_LSB +: 5] == STAT_CH_TOP &&
            wb_dat_o[0] == ctrl_enable;
    endproperty
    a_stat: assert property (p_stat)
        else $error("status read wrong");

    property p_adb;
        acc && !wb_we_i && wb_adr_i == A_ADB |=> wb_dat_o == 32'h0000_0200;
    endproperty
    a_adb: assert property (p_adb)
        else $error("alternate base read wrong");

    property p_wo_zero;
        acc && !wb_we_i && (wb_adr_i == A_EN_CLR || wb_adr_i == A_PRI_SET)
        |=> wb_dat_o == 32'h0000_0000;
    endproperty
    a_wo_zero: assert property (p_wo_zero)
        else $error("write-only register read nonzero");

    property p_sw_req_done;
        st_q.sw_req[2] && chan_done[2] && !wr |=> !st_q.sw_req[2];
    endproperty
    a_sw_req_done: assert property (p_sw_req_done)
        else $error("software request not cleared on completion");

    property p_sw_req_set;
        wr && wb_adr_i == A_SW_REQ && wb_sel_i[0] && wb_dat_i[2]
        |=> st_q.sw_req[2];
    endproperty
    a_sw_req_set: assert property (p_sw_req_set)
        else $error("software request lost");

    property p_err_sticky;
        // A clear write in the cycle after may legally drop the flag
        chan_err_evt[3] |=> st_q.cherr[3] ##1 (st_q.cherr[3] ||
            ($past(wr) && $past(wb_adr_i) == A_CHERR_CLR));
    endproperty
    a_err_sticky: assert property (p_err_sticky)
        else $error("channel error flag lost");

    property p_trig;
        dma_req[TRIG_CH0] && !$past(st_q.sw_req[TRIG_CH0])
        |-> $past(st_q.trig_en[0]) && $past(st_q.men);
    endproperty
    a_trig: assert property (p_trig)
        else $error("trigger request without enables");

    property p_ack;
        acc |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack)
        else $error("bus ack timing wrong");

    property p_mask;
        st_q.mask[6] && !st_q.sw_req[6] |=> !dma_req[6];
    endproperty
    a_mask: assert property (p_mask)
        else $error("masked request reached the engine");

    property p_burst;
        st_q.burst[3:0] == 4'h2 |-> burst_len_zero == 11'h004;
    endproperty
    a_burst: assert property (p_burst)
        else $error("burst length wrong for exponent two");

    property p_irq_off;
        !st_q.flash[FLASH_IRQ_EN] |=> !flash_dma_irq;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("flash interrupt while disabled");

    c_flash: cover property (chan_done[FLASH_CH] ##1 flash_dma_irq);
    c_trig:  cover property (trig_hit[0] ##1 dma_req[TRIG_CH0]);
    c_sw_done: cover property (|(st_q.sw_req & chan_done));
    c_abort: cover property (|chan_abort);

endmodule

// File: logic/dcr_pkg.sv
package dcr_pkg;
    localparam int          NCH          = 31;
    localparam int          FLASH_CH     = 21;
    localparam int          TRIG_CH0     = 27;
    localparam int          TRIG_CH1     = 28;
    localparam int          NTRIG        = 2;
    localparam int          NPLA         = 4;
    localparam int          NTMR         = 4;

    // Request-routing window
    localparam logic [31:0] A_TRIG_EN    = 32'h4000_7000;
    localparam logic [31:0] A_TRIG_SEL0  = 32'h4000_7004;
    localparam logic [31:0] A_TRIG_SEL1  = 32'h4000_7008;
    localparam logic [31:0] A_PLA_EN     = 32'h4000_700c;
    localparam logic [31:0] A_TMR_EN     = 32'h4000_7010;
    localparam logic [31:0] A_TMR_TYPE   = 32'h4000_7014;
    localparam logic [31:0] A_TRIG_BURST = 32'h4000_7018;
    // Controller window
    localparam logic [31:0] A_STAT       = 32'h4004_0000;
    localparam logic [31:0] A_CFG        = 32'h4004_0004;
    localparam logic [31:0] A_PDB        = 32'h4004_0008;
    localparam logic [31:0] A_ADB        = 32'h4004_000c;
    localparam logic [31:0] A_SW_REQ     = 32'h4004_0014;
    localparam logic [31:0] A_MSK_SET    = 32'h4004_0020;
    localparam logic [31:0] A_MSK_CLR    = 32'h4004_0024;
    localparam logic [31:0] A_EN_SET     = 32'h4004_0028;
    localparam logic [31:0] A_EN_CLR     = 32'h4004_002c;
    localparam logic [31:0] A_ALT_SET    = 32'h4004_0030;
    localparam logic [31:0] A_ALT_CLR    = 32'h4004_0034;
    localparam logic [31:0] A_PRI_SET    = 32'h4004_0038;
    localparam logic [31:0] A_PRI_CLR    = 32'h4004_003c;
    localparam logic [31:0] A_CHERR_CLR  = 32'h4004_0048;
    localparam logic [31:0] A_BUSERR_CLR = 32'h4004_004c;
    localparam logic [31:0] A_INVD_CLR   = 32'h4004_0050;
    localparam logic [31:0] A_FLASH_CTRL = 32'h4004_0100;
    localparam logic [31:0] A_BS_SET     = 32'h4004_0800;
    localparam logic [31:0] A_BS_CLR     = 32'h4004_0804;
    localparam logic [31:0] A_SDEC_SET   = 32'h4004_0810;
    localparam logic [31:0] A_SDEC_CLR   = 32'h4004_0814;
    localparam logic [31:0] A_DDEC_SET   = 32'h4004_0818;
    localparam logic [31:0] A_DDEC_CLR   = 32'h4004_081c;
    localparam logic [31:0] A_REV_ID     = 32'h4004_0fe0;

    localparam logic [31:0] STAT_RST     = 32'h001e_0000;
    localparam logic [4:0]  STAT_CH_TOP  = 5'h1e;
    localparam int          STAT_CH_LSB  = 16;
    localparam logic [31:0] ADB_RST      = 32'h0000_0200;
    localparam logic [31:0] PDB_RST      = 32'h0000_0000;
    localparam logic [7:0]  SEL_TMR_BASE = 8'h04;
    localparam int          FLASH_IRQ_EN = 0;
    localparam int          FLASH_BLOCK  = 1;
endpackage

// File: test/dcr_engine_model.sv
`timescale 1ns/1ps
module dcr_engine_model
    import dcr_pkg::*;
(
    input  wire logic           ref_clk,
    input  wire logic           rst_n,
    input  wire logic           slow,
    input  wire logic [NCH-1:0] dma_req,
    input  wire logic [NCH-1:0] chan_enable,
    output logic      [NCH-1:0] chan_done
);
    int cnt;
    int ch;
    // One channel in service at a time, lowest number wins
    // Two idle cycles after done let the request fall before rearming
    always @(posedge ref_clk) begin
        chan_done <= '0;
        if (!rst_n) begin
            cnt <= 0;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
            if (cnt == 3) begin
                chan_done[ch] <= 1'b1;
            end
        end else if (|(dma_req & chan_enable)) begin
            for (int c = NCH - 1; c >= 0; c--) begin
                if (dma_req[c] && chan_enable[c]) begin
                    ch <= c;
                end
            end
            cnt <= slow ? 12 : 4;
        end
    end
endmodule

// File: test/tb.sv
`timescale 1ns/1ps
module tb
    import dcr_pkg::*;
;
    typedef struct packed {logic [31:0] a; logic [31:0] e;} dcr_row_type;
    logic            ref_clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0;
    logic            we = 1'b0, bus_err = 1'b0, slow = 1'b0;
    logic            ack, fsel, irq, men;
    logic [3:0]      sel = 4'h0;
    logic [31:0]     adr = '0, wdat = '0, dout, rdat, pbase, abase;
    logic [NCH-1:0]  chan_err = '0, inv_desc = '0, abort_seen = '0;
    logic [NCH-1:0]  preq = '0;
    logic [NCH-1:0]  dma_req, done, en, abort_v, pri;
    logic [NCH-1:0]  attr [5];
    logic [NPLA-1:0] pla = '0;
    logic [10:0]     b0, b1;
    int              error_cnt = 0, checks = 0, cyc_cnt = 0, irq_cnt = 0;
    logic [31:0]     sets [5] = '{A_MSK_SET, A_ALT_SET, A_BS_SET,
                                  A_SDEC_SET, A_DDEC_SET};
    dcr_row_type     rows [13] = '{'{A_STAT, STAT_RST}, '{A_ADB, ADB_RST},
        '{A_PDB, PDB_RST}, '{A_TRIG_EN, 0}, '{A_TRIG_SEL0, 0},
        '{A_TRIG_SEL1, 0}, '{A_PLA_EN, 0}, '{A_TMR_EN, 0}, '{A_TMR_TYPE, 0},
        '{A_SW_REQ, 0}, '{A_EN_CLR, 0}, '{A_PRI_SET, 0}, '{32'h4004_0040, 0}};

    always #2 ref_clk = ~ref_clk;

    dcr_top i_dcr_top (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack),
        .periph_req(preq), .chan_done(done), .chan_err_evt(chan_err),
        .inv_desc_evt(inv_desc), .bus_err_evt(bus_err), .pla_req(pla),
        .timer_req('0), .dma_req(dma_req), .chan_enable(en),
        .chan_abort(abort_v), .chan_mask(attr[0]), .chan_alt(attr[1]),
        .chan_pri(pri), .byte_swap(attr[2]), .src_dec(attr[3]),
        .dst_dec(attr[4]), .ctrl_enable(men), .primary_base(pbase),
        .alternate_base(abase), .burst_len_zero(b0), .burst_len_one(b1),
        .flash_block_sel(fsel), .flash_dma_irq(irq));

    dcr_engine_model i_dcr_engine_model (.ref_clk(ref_clk), .rst_n(rst_n),
        .slow(slow), .dma_req(dma_req), .chan_enable(en), .chan_done(done));

    ////////////////////////////////////////////////////////////////////////
    always @(posedge ref_clk) begin
        cyc_cnt <= cyc_cnt + 1;
        // Unknown state before the first reset edge must not stick
        if (rst_n) begin
            abort_seen <= abort_seen | abort_v;
        end
        if (irq === 1'b1) begin
            irq_cnt <= irq_cnt + 1;
        end
        if (cyc_cnt == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    task automatic chk(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Master holds everything until ack is sampled high
    task automatic wb(input logic w, input logic [31:0] a,
                      input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        @(posedge ref_clk);
        while (ack !== 1'b1) @(posedge ref_clk);
        rdat = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rc(input string nm, input logic [31:0] a,
                      input logic [31:0] e);
        wb(1'b0, a, '0);
        chk(nm, rdat, e);
    endtask

    // Bounded wait; the comparison after it decides
    task automatic wt(input int c, input logic v);
        for (int n = 0; n < 40 && dma_req[c] !== v; n++) @(posedge ref_clk);
        chk("dma_req", {31'h0, dma_req[c]}, {31'h0, v});
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        foreach (rows[i]) rc("reset row", rows[i].a, rows[i].e);
        chk("alternate port", abase, ADB_RST);
        $display("reset values done");
        wb(1'b1, A_PDB, 32'h2000_0400);
        rc("primary base", A_PDB, 32'h2000_0400);
        chk("primary port", pbase, 32'h2000_0400);
        wb(1'b1, A_ADB, 32'h0000_1000);
        rc("alternate base", A_ADB, ADB_RST);
        // Config is only ever written nonzero
        wb(1'b1, A_CFG, 32'h1);
        rc("status", A_STAT, STAT_RST | 32'h1);
        chk("ctrl enable", {31'h0, men}, 32'h1);
        foreach (sets[i]) begin
            wb(1'b1, sets[i], 32'h5);
            wb(1'b1, sets[i] + 32'h4, 32'h1);
            wb(1'b1, sets[i] + 32'h4, 32'h0);
            rc("set reg", sets[i], 32'h4);
            rc("clear reg", sets[i] + 32'h4, '0);
            chk("attr port", {1'b0, attr[i]}, 32'h4);
            wb(1'b1, sets[i] + 32'h4, 32'h7fff_ffff);
        end
        wb(1'b1, A_PRI_SET, 32'h3);
        wb(1'b1, A_PRI_CLR, 32'h1);
        rc("priority read", A_PRI_SET, '0);
        chk("priority port", {1'b0, pri}, 32'h2);
        $display("attribute registers done");
        wb(1'b1, A_EN_SET, 32'hf0);
        wb(1'b1, A_EN_CLR, 32'h10);
        rc("enable", A_EN_SET, 32'he0);
        chk("abort", {1'b0, abort_seen}, 32'h10);
        wb(1'b1, A_EN_SET, 32'h4);
        wb(1'b1, A_SW_REQ, 32'h4);
        wt(2, 1'b1);
        wt(2, 1'b0);
        // Mask stops hardware requests only
        preq <= 31'h40;
        wt(6, 1'b1);
        wb(1'b1, A_MSK_SET, 32'h40);
        wt(6, 1'b0);
        preq <= '0;
        wb(1'b1, A_MSK_CLR, 32'h40);
        $display("enable and software request done");
        wb(1'b1, A_EN_SET, 32'h1800_0000);
        wb(1'b1, A_TRIG_EN, 32'h1);
        for (int s = 0; s < NPLA; s++) begin
            pla <= 4'h1 << s;
            wb(1'b1, A_TRIG_SEL0, 32'(s));
            wb(1'b1, A_PLA_EN, 32'h0);
            repeat (3) @(posedge ref_clk);
            chk("gated", {31'h0, dma_req[TRIG_CH0]}, 32'h0);
            wb(1'b1, A_PLA_EN, 32'h1 << s);
            wt(TRIG_CH0, 1'b1);
        end
        wb(1'b1, A_TRIG_EN, 32'h0);
        wt(TRIG_CH0, 1'b0);
        wb(1'b1, A_TRIG_EN, 32'h2);
        wb(1'b1, A_TRIG_SEL1, 32'h3);
        wt(TRIG_CH1, 1'b1);
        wb(1'b1, A_TRIG_EN, 32'h0);
        // Exponent 2: four transfers per request
        wb(1'b1, A_TRIG_BURST, 32'h2);
        chk("burst", {21'h0, b0}, 32'h4);
        chk("burst one", {21'h0, b1}, 32'h1);
        $display("trigger routing done");
        chan_err <= 31'h8;
        inv_desc <= 31'h20;
        bus_err <= 1'b1;
        @(posedge ref_clk);
        chan_err <= '0;
        inv_desc <= '0;
        bus_err <= 1'b0;
        rc("chan err", A_CHERR_CLR, 32'h8);
        rc("bus err", A_BUSERR_CLR, 32'h1);
        wb(1'b1, A_CHERR_CLR, 32'h8);
        rc("chan err clr", A_CHERR_CLR, 32'h0);
        rc("inv desc kept", A_INVD_CLR, 32'h20);
        $display("error flags done");
        wb(1'b1, A_FLASH_CTRL, 32'h3);
        chk("flash block", {31'h0, fsel}, 32'h1);
        wb(1'b1, A_EN_SET, 32'h1 << FLASH_CH);
        // Irq marks transfer end only; flash busy is polled elsewhere
        for (int k = 0; k < 2; k++) begin
            wb(1'b1, A_SW_REQ, 32'h1 << FLASH_CH);
            wt(FLASH_CH, 1'b1);
            wt(FLASH_CH, 1'b0);
            repeat (2) @(posedge ref_clk);
            chk("flash irq", irq_cnt, 32'h1);
            // Second pass: interrupt off, slow engine
            slow <= 1'b1;
            wb(1'b1, A_FLASH_CTRL, 32'h0);
        end
        $display("flash channel done");
        rst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rc("base after reset", A_PDB, PDB_RST);
        rc("trig after reset", A_TRIG_EN, 32'h0);
        chk("enable after reset", {1'b0, en}, 32'h0);
        $display("second reset done");
        tally_and_finish();
    end
endmodule
